// ===== osc_clock_watchdog_timer_tb.sv
// osc_clock_watchdog_timer_tb: self-checking bench for owdt_top over apb
// assumes: owdt_pkg compiled first; counter and pulse shortened by parameters
`timescale 1ns/10ps
`default_nettype none
`include "owdt_params.svh"
module osc_clock_watchdog_timer_tb;
    localparam int PC = 16; // shortened pulse, keeps the run brief
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    owdt_pkg::owdt_cond_s cond = '0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd_v;
    logic pready, pslverr, err_v, rst_o_n, irq_n, wake, osc_en;
    int wake_cnt, rst_cnt, cyc;
    int fail_count = 0;
    int samples_checked = 0;

    owdt_top #(.CNT_W(4), .PULSE_CYC(PC)) dut (.clk(clk), .rst_n(rst_n), .osc_en(osc_en),
        .cond(cond), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .wdog_reset_out_n(rst_o_n), .wdog_irq_n(irq_n), .wake_irq(wake));
    owdt_partner prt (.clk(clk), .rst_n(rst_n), .stop(cond.halt), .wake(wake),
        .rst_req_n(rst_o_n), .osc_en(osc_en), .wake_cnt(wake_cnt), .rst_cnt(rst_cnt));

    always #12.5 clk = ~clk;

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic ok(input logic b, input string m);
        check({31'h0, b}, 32'h1, m);
    endtask
    // one apb transfer; request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd_v = prdata;
        err_v = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string m);
        apb(1'b0, a, 32'h0);
        check(rd_v, e, m);
    endtask
    task automatic kick;
        wr(`OWDT_OFF_KEY, 32'h55);
        wr(`OWDT_OFF_KEY, 32'haa);
    endtask
    // edges until the chosen pin reads lv, bounded by lim
    task automatic wait_pin(input logic irq, input logic lv, input int lim, output int n);
        n = 0;
        while ((irq ? irq_n : rst_o_n) !== lv && n < lim) begin
            @(posedge clk);
            n++;
        end
    endtask

    task automatic t_regs;
        rdchk(`OWDT_OFF_SYSTEM_CONTROL_STATUS, 32'h5, "system_control_status reset");
        rdchk(`OWDT_OFF_CTRL, 32'h0, "ctrl reset");
        rdchk(`OWDT_OFF_KEY, 32'h0, "key reads ctrl");
        apb(1'b0, 8'h10, 32'h0);
        ok(err_v, "unmapped err");
        check(rd_v, 32'h0, "unmapped data");
        $display("test regs done");
    endtask
    // counter frozen so every count compares exactly
    task automatic t_key;
        logic [31:0] c;
        kick;
        repeat (1200) @(posedge clk);
        cond.cpu_susp <= 1'b1;
        apb(1'b0, `OWDT_OFF_CNT, 32'h0);
        c = rd_v;
        ok(c != 32'h0, "count runs");
        wr(`OWDT_OFF_CNT, 32'hff);
        wr(`OWDT_OFF_KEY, 32'h55);
        wr(`OWDT_OFF_KEY, 32'h32);
        wr(`OWDT_OFF_KEY, 32'haa);
        rdchk(`OWDT_OFF_CNT, c, "no clear");
        wr(`OWDT_OFF_KEY, 32'h55);
        kick;
        rdchk(`OWDT_OFF_CNT, 32'h0, "key clear");
        cond.cpu_susp <= 1'b0;
        $display("test key done");
    endtask
    // two ticks must take 2*512*div cycles for prescale codes 0 to 3
    task automatic t_prescale;
        logic [31:0] c;
        int div;
        for (int ps = 0; ps < 4; ps++) begin
            div = (ps < 2) ? 1 : (1 << (ps - 1));
            wr(`OWDT_OFF_CTRL, 32'h28 | ps);
            rdchk(`OWDT_OFF_CTRL, ps, "check reads 0");
            kick;
            apb(1'b0, `OWDT_OFF_CNT, 32'h0);
            c = rd_v;
            repeat (1024 * div - 3) @(posedge clk);
            rdchk(`OWDT_OFF_CNT, c + 32'd2, "tick rate");
        end
        wr(`OWDT_OFF_CTRL, 32'h28);
        $display("test prescale done");
    endtask
    task automatic t_debug;
        logic [3:0] md [4] = '{4'h8, 4'h4, 4'h2, 4'h1};
        logic [31:0] c;
        for (int i = 0; i < 4; i++) begin
            kick;
            cond <= owdt_pkg::owdt_cond_s'(md[i]);
            apb(1'b0, `OWDT_OFF_CNT, 32'h0);
            c = rd_v;
            repeat (1021) @(posedge clk);
            rdchk(`OWDT_OFF_CNT, c + ((i == 3) ? 32'd2 : 32'd0), "debug");
            cond <= '0;
        end
        $display("test debug done");
    endtask
    task automatic t_irq;
        int n, w0, r0;
        wr(`OWDT_OFF_SYSTEM_CONTROL_STATUS, 32'h2);
        kick;
        w0 = wake_cnt;
        r0 = rst_cnt;
        wait_pin(1'b1, 1'b0, 9000, n);
        ok(n < 9000, "overflow irq");
        wait_pin(1'b1, 1'b1, PC + 8, n);
        ok(n >= PC && n <= PC + 2, "irq width");
        check(32'(wake_cnt - w0), 32'h1, "one wake");
        check(32'(rst_cnt - r0), 32'h0, "no reset");
        repeat (2) @(posedge clk);
        rdchk(`OWDT_OFF_SYSTEM_CONTROL_STATUS, 32'h7, "state idle");
        $display("test irq done");
    endtask
    task automatic t_switch;
        int n, r0;
        kick;
        r0 = rst_cnt;
        wr(`OWDT_OFF_CTRL, 32'h0);
        wait_pin(1'b1, 1'b0, 8, n);
        ok(n < 8, "bad check irq");
        // status bit trails the pin by two clocks; let it catch up first
        repeat (2) @(posedge clk);
        rdchk(`OWDT_OFF_SYSTEM_CONTROL_STATUS, 32'h3, "state active");
        wr(`OWDT_OFF_SYSTEM_CONTROL_STATUS, 32'h0);
        wait_pin(1'b0, 1'b0, 4, n);
        ok(n < 4, "switch resets");
        repeat (2) @(posedge clk);
        ok(irq_n, "irq off in reset");
        wait_pin(1'b0, 1'b1, PC + 8, n);
        ok(n + 2 >= PC && n <= PC, "reset width");
        check(32'(rst_cnt - r0), 32'h1, "one reset");
        rdchk(`OWDT_OFF_CTRL, 32'h80, "flag set");
        wr(`OWDT_OFF_CTRL, 32'h28);
        rdchk(`OWDT_OFF_CTRL, 32'h80, "flag kept");
        wr(`OWDT_OFF_CTRL, 32'ha8);
        rdchk(`OWDT_OFF_CTRL, 32'h0, "flag cleared");
        $display("test switch done");
    endtask
    task automatic t_off;
        wr(`OWDT_OFF_CTRL, 32'h68);
        rdchk(`OWDT_OFF_CTRL, 32'h40, "off set");
        repeat (1100) @(posedge clk);
        rdchk(`OWDT_OFF_CNT, 32'h0, "held off");
        wr(`OWDT_OFF_CTRL, 32'h40);
        repeat (8) @(posedge clk);
        ok(rst_o_n & irq_n, "no timeout off");
        wr(`OWDT_OFF_SYSTEM_CONTROL_STATUS, 32'h1);
        rdchk(`OWDT_OFF_SYSTEM_CONTROL_STATUS, 32'h4, "unlock cleared");
        wr(`OWDT_OFF_CTRL, 32'h28);
        rdchk(`OWDT_OFF_CTRL, 32'h40, "off locked");
        $display("test off done");
    endtask

    task automatic give_verdict;
        $display("checks %0d failures %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // hang guard, well above the roughly 23k cycles the tests need
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            fail_count++;
            $display("CHECK FAILED t=%0t timeout", $time);
            give_verdict;
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_regs;
        t_key;
        t_prescale;
        t_debug;
        t_irq;
        t_switch;
        t_off;
        give_verdict;
    end
endmodule
`default_nettype wire

// ===== owdt_params.svh
// owdt register map, field positions, reset values and counts
// assumes: included by owdt_pkg and owdt_top; definitions only
`ifndef OWDT_PARAMS_SVH
`define OWDT_PARAMS_SVH

`define OWDT_OFF_SYSTEM_CONTROL_STATUS    8'h00
`define OWDT_OFF_CNT     8'h04
`define OWDT_OFF_KEY     8'h08
`define OWDT_OFF_CTRL    8'h0c

`define OWDT_SC_UNLOCK   0
`define OWDT_SC_MODE     1
`define OWDT_SC_IRQST    2

`define OWDT_CR_PS_LO    0
`define OWDT_CR_CHK_LO   3
`define OWDT_CR_OFF      6
`define OWDT_CR_FLAG     7

`define OWDT_RST_PS      3'h0
`define OWDT_RST_MODE    1'b0
`define OWDT_RST_UNLOCK  1'b1
`define OWDT_RST_OFF     1'b0

`define OWDT_CHK_GOOD    3'h5
`define OWDT_KEY_ARM     8'h55
`define OWDT_KEY_FIRE    8'haa

`define OWDT_PULSE_CYC   512
`define OWDT_BASE_DIV    512

`endif

// ===== owdt_partner.sv
// owdt_partner: oscillator, interrupt expander and reset sink around owdt_top
// assumes: shares clk with owdt_top; stop high models the oscillator being off
`timescale 1ns/10ps
`default_nettype none
module owdt_partner (
    input  wire logic clk,       // system clock
    input  wire logic rst_n,     // async reset, low
    input  wire logic stop,      // oscillator off
    input  wire logic wake,      // wake strobe from the watchdog
    input  wire logic rst_req_n, // watchdog reset request, low
    output logic      osc_en,    // oscillator strobe
    output int        wake_cnt,  // wake interrupts taken
    output int        rst_cnt    // reset pulses seen
);
    logic rst_q; // last reset request level
    // oscillator runs at clk rate; halt removes it entirely
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_en <= 1'b0;
        end else begin
            osc_en <= !stop;
        end
    end
    // expander and power unit take one interrupt per strobe, never a level
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_cnt <= 0;
            rst_cnt <= 0;
            rst_q <= 1'b1;
        end else begin
            rst_q <= rst_req_n;
            if (wake) wake_cnt <= wake_cnt + 1;
            if (rst_q && !rst_req_n) rst_cnt <= rst_cnt + 1;
        end
    end
endmodule
`default_nettype wire

// ===== owdt_pkg.sv
// owdt types shared by the top and its bench
// assumes: owdt_params.svh sits in the include path
`include "owdt_params.svh"

package owdt_pkg;

    // output pulse state
    typedef enum logic [1:0] {
        PL_IDLE,
        PL_RESET,
        PL_IRQ
    } owdt_pulse_e;

    // power and debug conditions from the system
    typedef struct packed {
        logic halt;      // oscillator stopped
        logic cpu_susp;  // cpu halted by debugger
        logic rt_step;   // real-time single step
        logic run_free;  // run-free or real-time run-free
    } owdt_cond_s;

endpackage

// ===== owdt_top.sv
// owdt_top: oscillator-driven watchdog with apb registers
// assumes: osc_en is one pulse per oscillator cycle, synchronous to clk;
// assumes: wdog_reset_out_n is combined into the device reset outside.
//
// The register offsets and the APB register port were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "owdt_params.svh"

module owdt_top #(
    parameter int CNT_W     = 8,
    parameter int PULSE_CYC = `OWDT_PULSE_CYC
) (
    input  wire logic               clk,              // system clock, 40 MHz
    input  wire logic               rst_n,            // async reset, low
    input  wire logic               osc_en,           // oscillator cycle strobe
    input  wire owdt_pkg::owdt_cond_s cond,           // power/debug state
    input  wire logic               psel,             // apb select
    input  wire logic               penable,          // apb enable
    input  wire logic               pwrite,           // apb direction
    input  wire logic [7:0]         paddr,            // apb byte address
    input  wire logic [31:0]        pwdata,           // apb write data
    output logic [31:0]             prdata,           // apb read data
    output logic                    pready,           // apb ready
    output logic                    pslverr,          // apb error
    output logic                    wdog_reset_out_n, // reset request, low
    output logic                    wdog_irq_n,       // interrupt, low
    output logic                    wake_irq          // one-cycle wake strobe
);

    initial begin
        if (CNT_W < 2 || CNT_W > 16 || PULSE_CYC < 2 || PULSE_CYC > 1024)
            $error("owdt_top: unsupported CNT_W or PULSE_CYC");
    end

    localparam logic [9:0] PULSE_LAST = 10'(PULSE_CYC - 1);
    localparam logic [8:0] BASE_LAST  = 9'(`OWDT_BASE_DIV - 1);

    logic [CNT_W-1:0]     count_value_r;
    logic [8:0]           base_div_r;
    logic [5:0]           sub_div_r;
    logic [9:0]           pulse_cnt_r;
    owdt_pkg::owdt_pulse_e pulse_r;
    logic                 irq_mode_select_r;
    logic                 disable_unlock_r;
    logic                 wdog_off_bit_r;
    logic                 reset_source_flag_r;
    logic [2:0]           tick_prescale_r;
    logic                 key_armed_r;
    logic                 irq_s1_r;
    logic                 irq_state_bit_r;
    logic                 irq_n_d_r;
    logic [31:0]          prdata_nxt;
    logic                 dec_ok;

    // apb decode; writes land on the access cycle where pready is high
    wire acc    = psel & penable & pready;
    wire wr     = acc & pwrite & dec_ok;
    wire wr_sc  = wr & (paddr == `OWDT_OFF_SYSTEM_CONTROL_STATUS);
    wire wr_key = wr & (paddr == `OWDT_OFF_KEY);
    wire wr_cr  = wr & (paddr == `OWDT_OFF_CTRL);
    wire [7:0] key_byte = pwdata[7:0];
    wire [2:0] chk_in   = pwdata[`OWDT_CR_CHK_LO +: 3];

    // counter clock gating: halt kills the oscillator, debug freezes it
    wire run_ok = osc_en & ~cond.halt & ~cond.cpu_susp & ~cond.rt_step;
    // run-free debug leaves run_ok untouched, standby never gates it
    wire base_wrap = run_ok & (base_div_r == BASE_LAST);

    // divide-by mask: codes 0 and 1 both give 1, then powers of two
    logic [5:0] sub_mask;
    always_comb begin
        sub_mask = 6'h00;
        if (tick_prescale_r > 3'h1)
            sub_mask = 6'((7'h01 << (tick_prescale_r - 3'h1)) - 7'h01);
    end
    wire wd_tick = base_wrap & ((sub_div_r & sub_mask) == sub_mask);

    wire key_clear = wr_key & key_armed_r & (key_byte == `OWDT_KEY_FIRE);
    wire overflow  = wd_tick & ~wdog_off_bit_r & (&count_value_r);
    wire bad_chk   = wr_cr & ~wdog_off_bit_r & (chk_in != `OWDT_CHK_GOOD);
    wire timeout   = overflow | bad_chk;
    // leaving interrupt mode during an active irq forces a reset
    wire mode_drop = wr_sc & ~pwdata[`OWDT_SC_MODE] & (pulse_r == owdt_pkg::PL_IRQ);

    // prescaler chain runs off oscillator strobes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            base_div_r <= 9'h000;
            sub_div_r  <= 6'h00;
        end else if (run_ok) begin
            base_div_r <= (base_div_r == BASE_LAST) ? 9'h000 : base_div_r + 9'h001;
            if (base_wrap)
                sub_div_r <= sub_div_r + 6'h01;
        end
    end

    // watchdog counter; disabled watchdog holds it at zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            count_value_r <= '0;
        else if (key_clear || wdog_off_bit_r)
            count_value_r <= '0;
        else if (wd_tick)
            count_value_r <= count_value_r + 1'b1;
    end

    // key sequencer: 0x55 arms, 0xaa fires once, anything else disarms
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            key_armed_r <= 1'b0;
        else if (wr_key) begin
            if (key_byte == `OWDT_KEY_ARM)
                key_armed_r <= 1'b1;
            else
                key_armed_r <= 1'b0;
        end
    end

    // system control bits
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_mode_select_r <= `OWDT_RST_MODE;
            disable_unlock_r  <= `OWDT_RST_UNLOCK;
        end else if (wr_sc) begin
            irq_mode_select_r <= pwdata[`OWDT_SC_MODE];
            if (pwdata[`OWDT_SC_UNLOCK])
                disable_unlock_r <= 1'b0;
        end
    end

    // control register; check field is never stored
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wdog_off_bit_r  <= `OWDT_RST_OFF;
            tick_prescale_r <= `OWDT_RST_PS;
        end else if (wr_cr) begin
            tick_prescale_r <= pwdata[`OWDT_CR_PS_LO +: 3];
            if (disable_unlock_r)
                wdog_off_bit_r <= pwdata[`OWDT_CR_OFF];
        end
    end

    // reset-source flag: our own reset request sets it, set beats clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            reset_source_flag_r <= 1'b0;
        else if (pulse_r == owdt_pkg::PL_RESET)
            reset_source_flag_r <= 1'b1;
        else if (wr_cr && pwdata[`OWDT_CR_FLAG])
            reset_source_flag_r <= 1'b0;
    end

    // output pulse, timed in oscillator cycles; it runs even when the
    // counter is frozen by debug, since it is already committed
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pulse_r     <= owdt_pkg::PL_IDLE;
            pulse_cnt_r <= 10'h000;
        end else if (mode_drop) begin
            pulse_r     <= owdt_pkg::PL_RESET;
            pulse_cnt_r <= 10'h000;
        end else if (pulse_r == owdt_pkg::PL_IDLE) begin
            if (timeout) begin
                pulse_r     <= irq_mode_select_r ? owdt_pkg::PL_IRQ
                                                 : owdt_pkg::PL_RESET;
                pulse_cnt_r <= 10'h000;
            end
        end else if (osc_en && !cond.halt) begin
            if (pulse_cnt_r == PULSE_LAST)
                pulse_r <= owdt_pkg::PL_IDLE;
            pulse_cnt_r <= pulse_cnt_r + 10'h001;
        end
    end

    // pin outputs, one register stage each
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wdog_reset_out_n <= 1'b1;
            wdog_irq_n       <= 1'b1;
        end else begin
            wdog_reset_out_n <= ~(pulse_r == owdt_pkg::PL_RESET);
            wdog_irq_n       <= ~(pulse_r == owdt_pkg::PL_IRQ);
        end
    end

    // wake strobe on the falling edge only; also feeds the power unit
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_n_d_r <= 1'b1;
            wake_irq  <= 1'b0;
        end else begin
            irq_n_d_r <= wdog_irq_n;
            wake_irq  <= irq_n_d_r & ~wdog_irq_n;
        end
    end

    // two-stage sync of the irq level into the status bit
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_s1_r        <= 1'b1;
            irq_state_bit_r <= 1'b1;
        end else begin
            irq_s1_r        <= wdog_irq_n;
            irq_state_bit_r <= irq_s1_r;
        end
    end

    // read mux; key reads mirror the control register
    always_comb begin
        prdata_nxt = 32'h0000_0000;
        dec_ok     = 1'b1;
        unique case (paddr)
            `OWDT_OFF_SYSTEM_CONTROL_STATUS: begin
                prdata_nxt[`OWDT_SC_IRQST]  = irq_state_bit_r;
                prdata_nxt[`OWDT_SC_MODE]   = irq_mode_select_r;
                prdata_nxt[`OWDT_SC_UNLOCK] = disable_unlock_r;
            end
            `OWDT_OFF_CNT:
                prdata_nxt[CNT_W-1:0] = count_value_r;
            `OWDT_OFF_KEY, `OWDT_OFF_CTRL: begin
                prdata_nxt[`OWDT_CR_FLAG]         = reset_source_flag_r;
                prdata_nxt[`OWDT_CR_OFF]          = wdog_off_bit_r;
                prdata_nxt[`OWDT_CR_PS_LO +: 3]   = tick_prescale_r;
            end
            default:
                dec_ok = 1'b0;
        endcase
    end

    // apb slave: fixed one-cycle access phase
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel & ~penable & ~pready;
            pslverr <= psel & ~penable & ~pready & ~dec_ok;
            if (psel && !penable && !pwrite)
                prdata <= prdata_nxt;
        end
    end

    // ---- assertions ----
    sequence irq_start_s;
        $rose(pulse_r == owdt_pkg::PL_IRQ);
    endsequence
    sequence rst_start_s;
        $rose(pulse_r == owdt_pkg::PL_RESET);
    endsequence

    property pin_follows_p(logic st, logic pin);
        @(posedge clk) disable iff (!rst_n) st |=> !pin;
    endproperty

    irq_pin_low_a: assert property (pin_follows_p(pulse_r == owdt_pkg::PL_IRQ, wdog_irq_n))
        else $error("irq pin not low during irq pulse");
    rst_pin_low_a: assert property (pin_follows_p(pulse_r == owdt_pkg::PL_RESET, wdog_reset_out_n))
        else $error("reset pin not low during reset pulse");
    wake_edge_a: assert property (@(posedge clk) disable iff (!rst_n)
        wake_irq |-> $past(irq_n_d_r) && !$past(wdog_irq_n))
        else $error("wake strobe without falling irq edge");
    irq_sync_a: assert property (@(posedge clk) disable iff (!rst_n)
        irq_state_bit_r == $past(wdog_irq_n, 2))
        else $error("irq state bit not two cycles behind");
    mode_drop_a: assert property (@(posedge clk) disable iff (!rst_n)
        mode_drop |=> pulse_r == owdt_pkg::PL_RESET ##1 !wdog_reset_out_n)
        else $error("mode change during irq did not reset");
    irq_mode_a: assert property (@(posedge clk) disable iff (!rst_n)
        irq_start_s |-> $past(irq_mode_select_r))
        else $error("irq pulse outside interrupt mode");
    freeze_cnt_a: assert property (@(posedge clk) disable iff (!rst_n)
        (cond.cpu_susp || cond.rt_step || cond.halt) && !key_clear && !wdog_off_bit_r
        |=> $stable(count_value_r))
        else $error("counter moved while suspended");
    unlock_a: assert property (@(posedge clk) disable iff (!rst_n)
        !disable_unlock_r |=> !disable_unlock_r)
        else $error("unlock bit came back");
    off_lock_a: assert property (@(posedge clk) disable iff (!rst_n)
        !disable_unlock_r |=> $stable(wdog_off_bit_r))
        else $error("off bit changed while locked");
    key_clr_a: assert property (@(posedge clk) disable iff (!rst_n)
        key_clear |=> count_value_r == '0)
        else $error("key sequence did not clear counter");
    flag_set_a: assert property (@(posedge clk) disable iff (!rst_n)
        rst_start_s |=> reset_source_flag_r)
        else $error("reset flag not set");
    bad_chk_a: assert property (@(posedge clk) disable iff (!rst_n)
        bad_chk && pulse_r == owdt_pkg::PL_IDLE |=> pulse_r != owdt_pkg::PL_IDLE)
        else $error("bad check field ignored");

endmodule
`default_nettype wire
